// ### rtl/mhcm_pkg.sv
package mhcm_pkg;

    // Cyclic frame layout of the slot 1 IO module
    localparam int unsigned FRAME_BYTES = 22;
    localparam int unsigned PARAM_WORDS = 4;
    localparam int unsigned PROC_WORDS  = 7;
    localparam int unsigned WORD_BITS   = 16;

    typedef struct packed {
        logic [PARAM_WORDS-1:0][WORD_BITS-1:0] parameter_channel_words;
        logic [PROC_WORDS-1:0][WORD_BITS-1:0]  process_data_words;
    } mhcm_frame_type;

    // Master control word fields
    localparam int unsigned CW_ON    = 0;
    localparam int unsigned CW_OFF2  = 1;
    localparam int unsigned CW_OFF3  = 2;
    localparam int unsigned CW_GRANT = 10;

    // Device status word fields
    localparam int unsigned SW_READY_ON  = 0;
    localparam int unsigned SW_READY     = 1;
    localparam int unsigned SW_OPERATE   = 2;
    localparam int unsigned SW_NO_OFF2   = 4;
    localparam int unsigned SW_NO_OFF3   = 5;
    localparam int unsigned SW_INHIBIT   = 6;
    localparam int unsigned SW_REQUEST   = 9;

    // Telegram fault bits of the extended error value
    localparam int unsigned ERR_BITS     = 11;
    localparam int unsigned EXT_BITS     = 16;

    // Diagnostic alarm record
    typedef struct packed {
        logic [7:0]  slot;
        logic [15:0] subslot;
        logic [15:0] channel;
        logic [7:0]  error_id;
        logic [7:0]  ext_type;
        logic [15:0] ext_value;
    } mhcm_diag_type;

    localparam logic [7:0]  DIAG_SLOT     = 8'h01;
    localparam logic [15:0] DIAG_SUBSLOT  = 16'h0001;
    localparam logic [15:0] DIAG_CHANNEL  = 16'h0001;
    localparam logic [7:0]  DIAG_ERROR_ID = 8'h1b;
    localparam logic [7:0]  DIAG_EXT_TYPE = 8'h01;

    // Status display characters
    localparam logic [7:0] DISP_TIMEOUT = 8'h79;
    localparam logic [7:0] DISP_NORMAL  = 8'h2d;

    // Sequencer states, Gray along the usual path
    typedef enum logic [1:0] {
        SEQ_INHIBIT = 2'b00,
        SEQ_READY   = 2'b01,
        SEQ_OPERATE = 2'b11
    } mhcm_seq_type;

    // Timing
    localparam int unsigned CLK_PERIOD_NS  = 10;
    localparam int unsigned MS_TIME_NS     = 1000000;
    localparam int unsigned MS_CYCLES_DEF  = (MS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned ALARM_HOLD_S   = 5;
    localparam int unsigned ALARM_HOLD_MS  = ALARM_HOLD_S * 1000;
    localparam int unsigned TO_OFF_DELAY_S = 2;
    localparam int unsigned TO_OFF_MS      = TO_OFF_DELAY_S * 1000;
    localparam int unsigned RAMP_MS_DEF    = 500;
    localparam int unsigned MS_CNT_BITS    = 17;
    localparam int unsigned TMR_BITS       = 16;
    localparam int unsigned PIN_COUNT      = 6;

endpackage : mhcm_pkg

// ### rtl/mhcm_sync.sv
`timescale 1ns/10ps
// Two-flop synchroniser for asynchronous pin levels
module mhcm_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         sys_clk,
    input  wire logic         reset,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule : mhcm_sync

// ### rtl/mhcm_hold_timer.sv
`timescale 1ns/10ps
// Millisecond hold timer: retrigger gives an off delay, else a minimum on time
module mhcm_hold_timer #(
    parameter bit          RETRIGGER = 1'b1,
    parameter int unsigned HOLD_MS   = 1
) (
    input  wire logic sys_clk,
    input  wire logic reset,
    input  wire logic ms_tick,
    input  wire logic cause,
    output logic      active
);

    logic [mhcm_pkg::TMR_BITS-1:0] cnt_q;
    logic                          cause_q;
    logic                          load;

    // One extra count so a partial first millisecond never shortens the hold
    assign load = RETRIGGER ? cause : (cause & ~cause_q);

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cause_q <= 1'b0;
        end else begin
            cause_q <= cause;
        end
    end

    // Countdown of the remaining hold
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cnt_q <= '0;
        end else if (load) begin
            cnt_q <= mhcm_pkg::TMR_BITS'(HOLD_MS + 1);
        end else if (ms_tick && cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    assign active = cause | (cnt_q != '0);

endmodule : mhcm_hold_timer

// ### rtl/mhcm_top.sv
`timescale 1ns/10ps
module mhcm_top #(
    parameter int unsigned MS_CYCLES      = mhcm_pkg::MS_CYCLES_DEF,
    parameter int unsigned ALARM_HOLD_MS  = mhcm_pkg::ALARM_HOLD_MS,
    parameter int unsigned TO_OFF_MS      = mhcm_pkg::TO_OFF_MS,
    parameter int unsigned RAMP_MS        = mhcm_pkg::RAMP_MS_DEF
) (
    input  wire logic                    sys_clk,
    input  wire logic                    reset,
    input  wire logic                    service_open_button,
    input  wire logic                    service_close_button,
    input  wire logic                    service_learn_button,
    input  wire logic                    service_tool_port_order,
    input  wire logic                    terminal_safety_state,
    input  wire logic                    protected_menu_active,
    input  wire logic                    provider_status_good,
    input  wire logic                    rx_frame_valid,
    input  wire mhcm_pkg::mhcm_frame_type rx_frame,
    input  wire logic [15:0]             process_timeout_limit,
    input  wire logic                    link_fault,
    input  wire logic [10:0]             telegram_errors,
    output logic                         internal_bus_halt,
    output logic                         pd_accept,
    output mhcm_pkg::mhcm_frame_type     accepted_frame,
    output mhcm_pkg::mhcm_frame_type     tx_frame,
    output logic [15:0]                  device_status_word,
    output mhcm_pkg::mhcm_seq_type       seq_state,
    output logic                         motor_ramp_down,
    output logic                         motor_deenergized,
    output logic                         local_mode,
    output logic                         timeout_alarm,
    output logic [7:0]                   status_display_code,
    output logic                         diag_alarm,
    output mhcm_pkg::mhcm_diag_type      diag_record
);

    logic [mhcm_pkg::PIN_COUNT-1:0]    pins_s;
    logic                              force_local;
    logic                              menu_s;
    logic [mhcm_pkg::MS_CNT_BITS-1:0]  ms_cnt_q;
    logic                              ms_tick;
    logic [15:0]                       to_cnt_q;
    logic                              timeout_raw;
    logic                              to_hold;
    logic                              alarm_hold;
    logic                              frame_ok;
    logic [15:0]                       cw;
    logic                              grant_q;
    logic                              ctl_ok;
    logic                              accept;
    logic [mhcm_pkg::ERR_BITS-1:0]     err_q;
    logic [15:0]                       ramp_q;
    mhcm_pkg::mhcm_seq_type            seq_d;

    // Operator pins are asynchronous to sys_clk
    mhcm_sync #(
        .W (mhcm_pkg::PIN_COUNT)
    ) u_pin_sync (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .async_in ({protected_menu_active, terminal_safety_state, service_tool_port_order,
                    service_learn_button, service_close_button, service_open_button}),
        .sync_out (pins_s)
    );

    assign force_local = |pins_s[4:0];
    assign menu_s      = pins_s[5];

    // Millisecond enable pulse
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ms_cnt_q <= '0;
        end else if (ms_tick) begin
            ms_cnt_q <= '0;
        end else begin
            ms_cnt_q <= ms_cnt_q + 1'b1;
        end
    end

    assign ms_tick = (ms_cnt_q == mhcm_pkg::MS_CNT_BITS'(MS_CYCLES - 1));

    // Bad provider status means the internal bus carries no user data
    assign frame_ok = rx_frame_valid & provider_status_good;
    assign cw       = rx_frame.process_data_words[0];

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            internal_bus_halt <= 1'b1;
        end else begin
            internal_bus_halt <= ~provider_status_good;
        end
    end

    // Local mode: forced by service inputs, left only once menus are clear
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            local_mode <= 1'b0;
        end else if (force_local) begin
            local_mode <= 1'b1;
        end else if (!menu_s) begin
            local_mode <= 1'b0;
        end
    end

    // Gap since last user data; limit chosen by the configurer with margin
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            to_cnt_q <= '0;
        end else if (process_timeout_limit == '0 || frame_ok) begin
            to_cnt_q <= '0;
        end else if (ms_tick && to_cnt_q < process_timeout_limit) begin
            to_cnt_q <= to_cnt_q + 1'b1;
        end
    end

    assign timeout_raw = (process_timeout_limit != '0) &&
                         (to_cnt_q >= process_timeout_limit);

    // Off delay on the timeout indication, no acknowledge needed
    mhcm_hold_timer #(
        .RETRIGGER (1'b1),
        .HOLD_MS   (TO_OFF_MS)
    ) u_to_hold (
        .sys_clk (sys_clk),
        .reset   (reset),
        .ms_tick (ms_tick),
        .cause   (timeout_raw),
        .active  (to_hold)
    );

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            timeout_alarm       <= 1'b0;
            status_display_code <= mhcm_pkg::DISP_NORMAL;
        end else begin
            timeout_alarm       <= to_hold;
            status_display_code <= to_hold ? mhcm_pkg::DISP_TIMEOUT
                                           : mhcm_pkg::DISP_NORMAL;
        end
    end

    // Grant is what the master last sent; lost on timeout or bad provider
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            grant_q <= 1'b0;
        end else if (timeout_raw || !provider_status_good) begin
            grant_q <= 1'b0;
        end else if (frame_ok) begin
            grant_q <= cw[mhcm_pkg::CW_GRANT];
        end
    end

    // A granting frame counts at once, so the first accept already advances
    assign ctl_ok = (frame_ok ? cw[mhcm_pkg::CW_GRANT] : grant_q) & ~local_mode;
    assign accept = frame_ok & cw[mhcm_pkg::CW_GRANT] & ~local_mode;

    // Accepted data goes out; discarded data never pulses pd_accept
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            pd_accept      <= 1'b0;
            accepted_frame <= '0;
        end else begin
            pd_accept <= accept;
            if (accept) begin
                accepted_frame <= rx_frame;
            end
        end
    end

    // Sequencer next state
    always_comb begin
        seq_d = seq_state;
        if (!ctl_ok || timeout_raw || !provider_status_good) begin
            seq_d = mhcm_pkg::SEQ_INHIBIT;
        end else if (accept) begin
            case (seq_state)
                mhcm_pkg::SEQ_INHIBIT: begin
                    if (cw[mhcm_pkg::CW_OFF2] && cw[mhcm_pkg::CW_OFF3] && !cw[mhcm_pkg::CW_ON])
                        seq_d = mhcm_pkg::SEQ_READY;
                end
                mhcm_pkg::SEQ_READY: begin
                    if (!(cw[mhcm_pkg::CW_OFF2] && cw[mhcm_pkg::CW_OFF3]))
                        seq_d = mhcm_pkg::SEQ_INHIBIT;
                    else if (cw[mhcm_pkg::CW_ON])
                        seq_d = mhcm_pkg::SEQ_OPERATE;
                end
                mhcm_pkg::SEQ_OPERATE: begin
                    if (!(cw[mhcm_pkg::CW_OFF2] && cw[mhcm_pkg::CW_OFF3]))
                        seq_d = mhcm_pkg::SEQ_INHIBIT;
                    else if (!cw[mhcm_pkg::CW_ON])
                        seq_d = mhcm_pkg::SEQ_READY;
                end
                default: seq_d = mhcm_pkg::SEQ_INHIBIT;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            seq_state <= mhcm_pkg::SEQ_INHIBIT;
        end else begin
            seq_state <= seq_d;
        end
    end

    // Ramp down on entering inhibit, then free-running; control word ignored
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ramp_q            <= '0;
            motor_ramp_down   <= 1'b0;
            motor_deenergized <= 1'b1;
        end else if (seq_d != mhcm_pkg::SEQ_INHIBIT) begin
            ramp_q            <= 16'(RAMP_MS + 1);
            motor_ramp_down   <= 1'b0;
            motor_deenergized <= 1'b0;
        end else if (ramp_q != '0) begin
            motor_ramp_down   <= 1'b1;
            if (ms_tick) begin
                ramp_q <= ramp_q - 1'b1;
            end
        end else begin
            motor_ramp_down   <= 1'b0;
            motor_deenergized <= 1'b1;
        end
    end

    // Status word and outgoing frame; parameter channel echoed as zero
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            device_status_word <= '0;
            tx_frame           <= '0;
        end else begin
            device_status_word <= '0;
            device_status_word[mhcm_pkg::SW_READY_ON] <= seq_d != mhcm_pkg::SEQ_INHIBIT;
            device_status_word[mhcm_pkg::SW_READY]    <= seq_d == mhcm_pkg::SEQ_OPERATE;
            device_status_word[mhcm_pkg::SW_OPERATE]  <= seq_d == mhcm_pkg::SEQ_OPERATE;
            device_status_word[mhcm_pkg::SW_NO_OFF2]  <= 1'b1;
            device_status_word[mhcm_pkg::SW_NO_OFF3]  <= 1'b1;
            device_status_word[mhcm_pkg::SW_INHIBIT]  <= seq_d == mhcm_pkg::SEQ_INHIBIT;
            device_status_word[mhcm_pkg::SW_REQUEST]  <= ~local_mode;
            tx_frame <= '0;
            tx_frame.process_data_words[0] <= {6'h00, ~local_mode, 1'b0, 1'b0,
                seq_d == mhcm_pkg::SEQ_INHIBIT, 1'b1, 1'b1, 1'b0,
                seq_d == mhcm_pkg::SEQ_OPERATE, seq_d == mhcm_pkg::SEQ_OPERATE,
                seq_d != mhcm_pkg::SEQ_INHIBIT};
        end
    end

    // Link alarm with minimum on time
    mhcm_hold_timer #(
        .RETRIGGER (1'b0),
        .HOLD_MS   (ALARM_HOLD_MS)
    ) u_alarm_hold (
        .sys_clk (sys_clk),
        .reset   (reset),
        .ms_tick (ms_tick),
        .cause   (link_fault),
        .active  (alarm_hold)
    );

    // Fault bits collect during an alarm episode; a new fault beats the clear
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            err_q <= '0;
        end else begin
            err_q <= (alarm_hold ? err_q : '0) | telegram_errors;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            diag_alarm  <= 1'b0;
            diag_record <= '0;
        end else begin
            diag_alarm            <= alarm_hold;
            diag_record.slot      <= mhcm_pkg::DIAG_SLOT;
            diag_record.subslot   <= mhcm_pkg::DIAG_SUBSLOT;
            diag_record.channel   <= mhcm_pkg::DIAG_CHANNEL;
            diag_record.error_id  <= mhcm_pkg::DIAG_ERROR_ID;
            diag_record.ext_type  <= mhcm_pkg::DIAG_EXT_TYPE;
            diag_record.ext_value <= {5'h00, (alarm_hold ? err_q : '0) | telegram_errors};
        end
    end

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    sequence s_to_end;
        $fell(timeout_raw);
    endsequence

    sequence s_alarm_start;
        $rose(diag_alarm);
    endsequence

    a_tx_status_word: assert property (
        tx_frame.process_data_words[0] == device_status_word)
        else $error("status word not in tx frame");
    a_link_alarm_rise: assert property (link_fault |=> diag_alarm)
        else $error("link fault did not raise alarm");
    a_alarm_min_hold: assert property (s_alarm_start |-> diag_alarm[*8])
        else $error("alarm dropped early");
    a_err_bit_zero: assert property (telegram_errors[0] |=> diag_record.ext_value[0])
        else $error("length error bit not set");
    a_err_bit_parity: assert property (telegram_errors[7] |=> diag_record.ext_value[7])
        else $error("parity error bit not set");
    a_err_reserved_zero: assert property (diag_record.ext_value[15:11] == '0)
        else $error("reserved error bits set");
    a_halt_on_bad: assert property (!provider_status_good |=> internal_bus_halt)
        else $error("bus not halted");
    a_request_bit_local: assert property (local_mode |=> !device_status_word[9])
        else $error("request bit high in local mode");
    a_accept_needs_grant: assert property (
        pd_accept |-> $past(rx_frame.process_data_words[0][10]) && $past(!local_mode))
        else $error("data accepted without grant");
    a_discard_no_grant: assert property (
        rx_frame_valid && !rx_frame.process_data_words[0][10] |=> !pd_accept)
        else $error("ungranted data accepted");
    a_local_forced: assert property (pins_s[0] |=> local_mode)
        else $error("button did not force local");
    a_local_menu_hold: assert property (local_mode && menu_s |=> local_mode)
        else $error("left local inside protected menu");
    a_timeout_inhibit: assert property (
        timeout_raw |=> seq_state == mhcm_pkg::SEQ_INHIBIT)
        else $error("timeout did not inhibit");
    a_zero_disables: assert property (process_timeout_limit == '0 |-> !timeout_raw)
        else $error("timeout with supervision off");
    a_timeout_display: assert property (
        timeout_alarm |-> status_display_code == mhcm_pkg::DISP_TIMEOUT)
        else $error("timeout code missing");
    a_timeout_off_delay: assert property (s_to_end |=> timeout_alarm[*8])
        else $error("off delay missing");
    a_deenergize_inhibit: assert property (
        motor_deenergized |-> seq_state == mhcm_pkg::SEQ_INHIBIT)
        else $error("de-energized outside inhibit");
    a_counter_restart: assert property (frame_ok |=> to_cnt_q == '0)
        else $error("counter not restarted");

endmodule : mhcm_top

// ### verification/mhcm_plc_model.sv
`timescale 1ns/10ps
// Master stand-in: one user data frame every GAP cycles while run is high
module mhcm_plc_model #(
    parameter int unsigned GAP = 20
) (
    input  wire logic                sys_clk,
    input  wire logic                reset,
    input  wire logic                run,
    input  wire logic [15:0]         control_word,
    output logic                     rx_frame_valid,
    output mhcm_pkg::mhcm_frame_type rx_frame
);
    int unsigned gap_q;

    // Gap below the bench limit, so steady traffic never trips it
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            gap_q          <= 0;
            rx_frame_valid <= 1'b0;
            rx_frame       <= '0;
        end else begin
            gap_q          <= (gap_q == GAP - 1) ? 0 : gap_q + 1;
            rx_frame_valid <= run && gap_q == 0;
            // Parameter words churn between frames, so no stale value looks valid
            rx_frame.parameter_channel_words <= {4{16'ha5a5 ^ 16'(gap_q)}};
            rx_frame.process_data_words      <= {80'h0, 16'h1234, control_word};
        end
    end
endmodule : mhcm_plc_model

// ### verification/mhcm_top_bench.sv
`timescale 1ns/10ps
// Self-checking bench: master model plus local pins, short ms and hold counts
module mhcm_top_bench;
    logic                     sys_clk, rx_valid, halt, acc, ramp, deen, loc, to_alarm, diag;
    logic                     reset = 1'b1, menu = 1'b0, good = 1'b1, run = 1'b0, link_fault = 1'b0;
    logic [4:0]               loc_src = '0;
    logic [10:0]              tel_err = '0;
    logic [15:0]              cw = 16'h0406, limit = 16'h0005, status;
    logic [7:0]               disp;
    mhcm_pkg::mhcm_frame_type rx_frame, acc_frame, tx_frame;
    mhcm_pkg::mhcm_seq_type   seq;
    mhcm_pkg::mhcm_diag_type  rec;
    int                       n_errors = 0, total_checks = 0, cycles = 0;

    mhcm_plc_model #(.GAP(20)) plc (.sys_clk(sys_clk), .reset(reset), .run(run),
        .control_word(cw), .rx_frame_valid(rx_valid), .rx_frame(rx_frame));
    mhcm_top #(.MS_CYCLES(10), .ALARM_HOLD_MS(20), .TO_OFF_MS(10), .RAMP_MS(4)) DUT (
        .sys_clk(sys_clk), .reset(reset), .service_open_button(loc_src[0]),
        .service_close_button(loc_src[1]), .service_learn_button(loc_src[2]),
        .service_tool_port_order(loc_src[3]), .terminal_safety_state(loc_src[4]),
        .protected_menu_active(menu), .provider_status_good(good),
        .rx_frame_valid(rx_valid), .rx_frame(rx_frame), .process_timeout_limit(limit),
        .link_fault(link_fault), .telegram_errors(tel_err), .internal_bus_halt(halt),
        .pd_accept(acc), .accepted_frame(acc_frame), .tx_frame(tx_frame),
        .device_status_word(status), .seq_state(seq), .motor_ramp_down(ramp),
        .motor_deenergized(deen), .local_mode(loc), .timeout_alarm(to_alarm),
        .status_display_code(disp), .diag_alarm(diag), .diag_record(rec));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Hang guard, well above the nine hundred or so cycles needed
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            n_errors++;
            test_done();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t %s: got %h want %h", $time, what, seen, exp);
        end
    endtask : check

    // Past the edge, so its updates have landed
    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : settle

    task automatic test_done();
        $display("Checks %0d, errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : test_done

    task automatic t_reset();
        check(status, 16'h0270, "status");
        check(tx_frame.process_data_words[0], 16'h0270, "tx word");
        check({rec.slot, rec.error_id}, 16'h011b, "diag id");
        check(rec.channel, 16'h0001, "diag chan");
        check(rec.subslot, 16'h0001, "diag sub");
        check(16'(rec.ext_type), 16'h0001, "diag ext");
    endtask : t_reset

    task automatic t_handoff();
        logic seen;
        seen = 1'b0;
        @(posedge sys_clk) run <= 1'b1;
        for (int i = 0; i < 40 && acc !== 1'b1; i++) settle(1);
        check(acc_frame.process_data_words[0], 16'h0406, "accepted");
        settle(2);
        check(seq, mhcm_pkg::SEQ_READY, "ready");
        @(posedge sys_clk) cw <= 16'h0407;
        settle(25);
        check(seq, mhcm_pkg::SEQ_OPERATE, "operate");
        @(posedge sys_clk) cw <= 16'h0007;
        settle(3);
        repeat (25) begin
            settle(1);
            seen |= acc;
        end
        check(seen, 1'b0, "no grant");
        check(seq, mhcm_pkg::SEQ_INHIBIT, "inhibit");
        check(ramp, 1'b1, "ramp");
        settle(60);
        check(deen, 1'b1, "free run");
        @(posedge sys_clk) cw <= 16'h0406;
    endtask : t_handoff

    // Each local source in turn, then the protected menu holds local mode
    task automatic t_local();
        for (int k = 0; k < 5; k++) begin
            @(posedge sys_clk) loc_src <= 5'(1 << k);
            settle(6);
            check(loc, 1'b1, "local");
            check(status[9], 1'b0, "request");
            @(posedge sys_clk) menu <= 1'b1;
            @(posedge sys_clk) loc_src <= '0;
            settle(6);
            check(loc, 1'b1, "menu");
            @(posedge sys_clk) menu <= 1'b0;
            settle(6);
            check(loc, 1'b0, "left");
        end
    endtask : t_local

    task automatic t_timeout();
        @(posedge sys_clk) limit <= 16'h0003;
        settle(30);
        @(posedge sys_clk) run <= 1'b0;
        for (int i = 0; i < 90 && to_alarm !== 1'b1; i++) settle(1);
        check(to_alarm, 1'b1, "timeout");
        check(seq, mhcm_pkg::SEQ_INHIBIT, "to inhibit");
        check(disp, 8'h79, "to code");
        @(posedge sys_clk) run <= 1'b1;
        settle(85);
        check(to_alarm, 1'b1, "off delay");
        settle(80);
        check(disp, 8'h2d, "no ack");
        @(posedge sys_clk) limit <= 16'h0000;
        @(posedge sys_clk) run <= 1'b0;
        settle(100);
        check(to_alarm, 1'b0, "disabled");
        @(posedge sys_clk) run <= 1'b1;
        settle(30);
    endtask : t_timeout

    task automatic t_provider();
        @(posedge sys_clk) good <= 1'b0;
        settle(3);
        check(halt, 1'b1, "halt");
        check(seq, mhcm_pkg::SEQ_INHIBIT, "bad prov");
        @(posedge sys_clk) good <= 1'b1;
        settle(3);
        check(halt, 1'b0, "resume");
    endtask : t_provider

    // Short link fault; every error bit accumulates, then the minimum hold
    task automatic t_diag();
        @(posedge sys_clk) link_fault <= 1'b1;
        settle(2);
        check(diag, 1'b1, "diag");
        for (int b = 0; b < 11; b++) begin
            @(posedge sys_clk) tel_err <= 11'(1 << b);
            @(posedge sys_clk) tel_err <= '0;
            settle(1);
            check(rec.ext_value, 16'((32'h2 << b) - 1), "bits");
        end
        @(posedge sys_clk) link_fault <= 1'b0;
        settle(140);
        check(diag, 1'b1, "hold");
        settle(80);
        check(diag, 1'b0, "end");
    endtask : t_diag

    initial begin
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
        settle(2);
        t_reset();
        t_handoff();
        t_local();
        t_timeout();
        t_provider();
        t_diag();
        test_done();
    end
endmodule : mhcm_top_bench
